// File: sbsc_pkg.sv
// Constants and types for the synchronous burst SRAM pin-level controller.
// Assumes a single 25 MHz clock shared with the bus master.
// Notes on behaviour
// RULE_01 - Device selected only when all three chip selects are active together.
// RULE_02 - Output enable low drives data pins; high three-states them as inputs.
// RULE_03 - First read clock after deselect keeps data pins three-stated despite enable.
// RULE_04 - Burst advance low at a clock edge moves to the next burst address.
// RULE_05 - Processor strobe latches the 17-bit address and seeds the burst counter.
// RULE_06 - With both strobes low, only the processor strobe is acted on; with first chip select high the code acts on the controller strobe.
// RULE_07 - Processor strobe is ignored while the first chip select is high.
// RULE_08 - Controller strobe latches the 17-bit address and seeds the burst counter.
// RULE_09 - Sleep input idles the device while memory contents are kept.
// RULE_10 - Unconnected sleep input leaves the device active.
// RULE_11 - Write data on the data pins is captured at the rising edge.
// RULE_12 - Read data appears one clock after its address is sampled.
// RULE_13 - Burst-order strap low selects linear, high or floating selects interleaved.
// RULE_14 - The system keeps the burst-order strap constant during operation.
// RULE_15 - Two-bit wraparound counter: linear adds one, interleaved uses XOR order.
// RULE_16 - Global write low writes all four lanes, ignoring byte write inputs.
// RULE_17 - Second chip select is active high; first chip select is active low.
// RULE_18 - A strobe with inactive chip selects deselects and three-states at once.
// RULE_19 - Burst advance high with no strobe holds the burst address.
package sbsc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int DEPTH = 131072;
  localparam logic [1:0] STEP_RST = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [DATA_W-1:0] DQ_RST = 32'h00000000;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic SLEEP_RST = 1'b0;
  localparam logic ORDER_RST = 1'b1;

  typedef enum logic {ST_DESEL, ST_ACTIVE} sbsc_state_t;

  // Low two address bits for burst step number step from start value base.
  function automatic logic [1:0] sbsc_burst_low(input logic [1:0] base,
                                                input logic [1:0] step,
                                                input logic ilv);
    sbsc_burst_low = ilv ? (base ^ step) : 2'(base + step);
  endfunction
endpackage

// File: sbsc_ctrl.sv
// Pin-level logic of a 128K x 32 pipelined synchronous burst SRAM.
// Assumes the bus master runs on ref_clk_i; output enable, sleep and the
// burst-order strap are asynchronous; the testbench resolves the data wire.
`timescale 1ns/1ps
module sbsc_ctrl
  import sbsc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic select_n_one_i,
  input wire logic select_pos_two_i,
  input wire logic select_n_three_i,
  input wire logic proc_strobe_n_i,
  input wire logic ctrl_strobe_n_i,
  input wire logic burst_step_n_i,
  input wire logic all_byte_write_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [LANES-1:0] byte_lane_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic sleep_req_i,
  input wire logic burst_order_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [2:0] sleep_sync_q;
  logic [2:0] order_sync_q;
  logic sleep_q;
  logic order_q;
  sbsc_state_t state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] base_q;
  logic [1:0] step_q;
  logic drive_ok_q;
  logic [DATA_W-1:0] dq_q;

  logic sel_active;
  logic proc_go;
  logic ctrl_go;
  logic strobe_go;
  logic start;
  logic deselect;
  logic cont;
  logic [1:0] step_n;
  logic [ADDR_W-1:0] eff_addr;
  logic [LANES-1:0] lane_we;
  logic mem_we;
  logic read_go;
  logic [DATA_W-1:0] rd_word;

  // Sleep and strap pass three flops; a level counts once flops 2 and 3 agree.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sleep_sync_q <= {3{SLEEP_RST}};
      sleep_q <= SLEEP_RST; // RULE_10
    end else begin
      sleep_sync_q <= {sleep_sync_q[1:0], sleep_req_i};
      if (sleep_sync_q[1] == sleep_sync_q[2]) begin
        sleep_q <= sleep_sync_q[2];
      end
    end
  end

  // The strap is sampled continuously; it is expected to stay static.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      order_sync_q <= {3{ORDER_RST}};
      order_q <= ORDER_RST; // RULE_13
    end else begin
      order_sync_q <= {order_sync_q[1:0], burst_order_i};
      if (order_sync_q[1] == order_sync_q[2]) begin
        order_q <= order_sync_q[2]; // RULE_14
      end
    end
  end

  assign sel_active = !select_n_one_i && select_pos_two_i &&
                      !select_n_three_i; // RULE_01 RULE_17
  assign proc_go = !proc_strobe_n_i && !select_n_one_i; // RULE_07
  assign ctrl_go = !ctrl_strobe_n_i && !proc_go; // RULE_06
  assign strobe_go = (proc_go || ctrl_go) && !sleep_q;
  assign start = strobe_go && sel_active;
  assign deselect = strobe_go && !sel_active; // RULE_18
  assign cont = !strobe_go && !sleep_q && (state_q == ST_ACTIVE);
  assign step_n = 2'(step_q + {1'b0, !burst_step_n_i}); // RULE_04 RULE_19

  always_comb begin
    if (start) begin
      eff_addr = addr_i;
    end else begin
      eff_addr = {addr_q[ADDR_W-1:2],
                  sbsc_burst_low(base_q, step_n, order_q)}; // RULE_15
    end
  end

  always_comb begin
    if (!all_byte_write_n_i) begin
      lane_we = LANES_ALL; // RULE_16
    end else if (!byte_write_gate_n_i) begin
      lane_we = ~byte_lane_sel_n_i;
    end else begin
      lane_we = LANES_NONE;
    end
  end

  // A processor-strobe start never writes; its write comes one clock later.
  assign mem_we = (cont || (start && !proc_go)) && (lane_we != LANES_NONE);
  assign read_go = (cont || start) && !mem_we;
  assign rd_word = mem_q[eff_addr];

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_DESEL;
    end else if (sleep_q) begin
      state_q <= ST_DESEL; // RULE_09
    end else if (start) begin
      state_q <= ST_ACTIVE;
    end else if (deselect) begin
      state_q <= ST_DESEL;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      addr_q <= ADDR_RST;
      base_q <= STEP_RST;
      step_q <= STEP_RST;
    end else if (start) begin
      addr_q <= addr_i; // RULE_05 RULE_08
      base_q <= addr_i[1:0];
      step_q <= STEP_RST;
    end else if (cont) begin
      step_q <= step_n; // RULE_04 RULE_19
    end
  end

  // Memory contents have no reset and survive sleep.
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem_q[eff_addr][8*i +: 8] <= dq_i[8*i +: 8]; // RULE_11
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dq_q <= DQ_RST;
    end else if (read_go) begin
      dq_q <= rd_word; // RULE_12
    end
  end

  // Drive only after a read that did not emerge from the deselected state.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      drive_ok_q <= 1'b0;
    end else begin
      drive_ok_q <= read_go && (state_q == ST_ACTIVE); // RULE_03 RULE_18
    end
  end

  assign dq_o = dq_q;
  assign dq_oe_o = drive_ok_q && !out_en_n_i && !sleep_q; // RULE_02 RULE_09

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence seq_read_start;
    start && !mem_we;
  endsequence

  sequence seq_fresh_read;
    seq_read_start ##0 (state_q == ST_DESEL);
  endsequence

  sequence seq_cont_step;
    cont && !burst_step_n_i;
  endsequence

  AST_OE_HIGH_TRISTATE: assert property ( // RULE_02
    out_en_n_i |-> !dq_oe_o)
    else $error("Data pins driven while output enable is high.");

  AST_FIRST_READ_MASK: assert property ( // RULE_03
    seq_fresh_read |=> !dq_oe_o)
    else $error("Data pins driven in first read clock after deselect.");

  AST_ADVANCE: assert property ( // RULE_04
    seq_cont_step |=> step_q == 2'($past(step_q) + STEP_ONE))
    else $error("Burst counter did not advance by one step.");

  AST_PROC_LOAD: assert property ( // RULE_05
    proc_go && sel_active && !sleep_q |=>
      addr_q == $past(addr_i) && step_q == STEP_RST)
    else $error("Processor strobe did not load address and counter.");

  AST_PROC_PRIORITY: assert property ( // RULE_06
    proc_go && !ctrl_strobe_n_i && sel_active |-> !mem_we)
    else $error("Controller strobe acted on alongside processor strobe.");

  AST_PROC_IGNORED: assert property ( // RULE_07
    !proc_strobe_n_i && select_n_one_i && ctrl_strobe_n_i &&
      state_q == ST_DESEL |=> $stable(addr_q) && !dq_oe_o)
    else $error("Processor strobe acted on with first select high.");

  AST_CTRL_LOAD: assert property ( // RULE_08
    ctrl_go && sel_active && !sleep_q |=> addr_q == $past(addr_i))
    else $error("Controller strobe did not load the address.");

  AST_SLEEP_QUIET: assert property ( // RULE_09
    sleep_q |=> !dq_oe_o && state_q == ST_DESEL)
    else $error("Device active during sleep.");

  AST_READ_LATENCY: assert property ( // RULE_12
    read_go |=> dq_o == $past(rd_word))
    else $error("Read data not presented one clock after address.");

  AST_GLOBAL_WRITE: assert property ( // RULE_16
    !all_byte_write_n_i |-> lane_we == LANES_ALL)
    else $error("Global write did not enable all lanes.");

  AST_DESEL_TRISTATE: assert property ( // RULE_18
    deselect |=> !dq_oe_o ##1 (!dq_oe_o || state_q == ST_ACTIVE))
    else $error("Outputs not three-stated after deselect.");

  AST_HOLD: assert property ( // RULE_19
    cont && burst_step_n_i |=> $stable(step_q))
    else $error("Burst address moved without advance.");
endmodule // sbsc_ctrl

// File: sbsc_host.sv
// Bus-master model: drives the SRAM pins and resolves the shared data wire.
// Assumes the device drives data only while its enable output is high.
`timescale 1ns/1ps
module sbsc_host
  import sbsc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [DATA_W-1:0] dev_dq_i,
  input wire logic dev_oe_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [2:0] sel_o,
  output logic proc_n_o,
  output logic ctrl_n_o,
  output logic step_n_o,
  output logic [5:0] wr_n_o,
  output logic [DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] wdata_q = '0;
  logic [DATA_W-1:0] last_q = '0;
  logic drive;
  assign drive = !wr_n_o[5] || !wr_n_o[4];
  // A released wire shows the inverse of its last value, not a held copy.
  assign dq_o = dev_oe_i ? dev_dq_i : drive ? wdata_q : ~last_q;
  always @(posedge ref_clk_i) begin
    last_q <= dq_o;
  end
  initial begin
    addr_o = '0;
    sel_o = 3'h0;
    proc_n_o = 1'b1;
    ctrl_n_o = 1'b1;
    step_n_o = 1'b1;
    wr_n_o = 6'h3F;
  end
  task automatic put(input logic [2:0] s, input logic p, c, st,
                     input logic [5:0] w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(negedge ref_clk_i);
    sel_o = s;
    proc_n_o = p;
    ctrl_n_o = c;
    step_n_o = st;
    wr_n_o = w;
    addr_o = a;
    wdata_q = d;
    @(posedge ref_clk_i);
    #1;
  endtask
endmodule // sbsc_host

// File: sync_burst_sram_control_pins_test.sv
// Self-checking bench for the burst SRAM pin logic.
// Assumes sbsc_host drives the bus and reset leaves memory untouched.
`timescale 1ns/1ps
module sync_burst_sram_control_pins_test;
  import sbsc_pkg::*;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [5:0] NW = 6'h3F;
  localparam logic [ADDR_W-1:0] BASE = 17'h00100;
  localparam logic [ADDR_W-1:0] FAR = 17'h1FFFF;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic oe_n = 1'b0;
  logic sleep = 1'b0;
  logic order = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [2:0] sel;
  logic proc_n, ctrl_n, step_n, dev_oe;
  logic [5:0] wr_n;
  logic [DATA_W-1:0] dq_w, dev_dq;
  int n_fail = 0;
  int samples_checked = 0;
  sbsc_host host (.ref_clk_i(clk), .dev_dq_i(dev_dq), .dev_oe_i(dev_oe),
    .addr_o(addr), .sel_o(sel), .proc_n_o(proc_n), .ctrl_n_o(ctrl_n),
    .step_n_o(step_n), .wr_n_o(wr_n), .dq_o(dq_w));
  sbsc_ctrl uut (.ref_clk_i(clk), .rstn_i(rstn), .addr_i(addr),
    .select_n_one_i(sel[2]), .select_pos_two_i(sel[1]),
    .select_n_three_i(sel[0]), .proc_strobe_n_i(proc_n),
    .ctrl_strobe_n_i(ctrl_n), .burst_step_n_i(step_n),
    .all_byte_write_n_i(wr_n[5]), .byte_write_gate_n_i(wr_n[4]),
    .byte_lane_sel_n_i(wr_n[3:0]), .out_en_n_i(oe_n),
    .sleep_req_i(sleep), .burst_order_i(order), .dq_i(dq_w),
    .dq_o(dev_dq), .dq_oe_o(dev_oe));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    pat = {a[15:0], a[15:0] ^ 16'hC3A5};
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_burst(input logic ilv, input logic [1:0] b);
    logic [1:0] lo;
    // The master lifts output enable before it presents write data.
    @(negedge clk);
    oe_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.put(ON, 1'b1, 1'b0, 1'b1, 6'h1F, BASE + 17'(i), pat(BASE + 17'(i)));
    end
    host.put(ON, 1'b1, 1'b1, 1'b1, NW, FAR, '0);
    rstn = 1'b0;
    order = ilv;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    oe_n = 1'b0;
    repeat (4) @(negedge clk);
    host.put(ON, 1'b0, 1'b1, 1'b1, NW, BASE | 17'(b), '0);
    chk(dev_dq, pat(BASE | 17'(b)), "first read");
    chk({31'h0, dev_oe}, '0, "masked");
    for (int k = 1; k < 4; k++) begin
      lo = ilv ? b ^ 2'(k) : 2'(b + 2'(k));
      host.put(ON, 1'b1, 1'b1, 1'b0, NW, FAR, '0);
      chk(dev_dq, pat({BASE[16:2], lo}), "burst");
      chk({31'h0, dev_oe}, 32'h1, "drive");
    end
    host.put(ON, 1'b1, 1'b1, 1'b1, NW, FAR, '0);
    chk(dev_dq, pat({BASE[16:2], lo}), "hold");
    host.put(3'h6, 1'b0, 1'b1, 1'b1, NW, FAR, '0);
    chk(dev_dq, pat({BASE[16:2], lo}), "gated strobe");
    chk({31'h0, dev_oe}, 32'h1, "gated strobe drive");
    @(negedge clk);
    oe_n = 1'b1;
    #1 chk({31'h0, dev_oe}, '0, "enable off");
    oe_n = 1'b0;
    $display("burst test done");
  endtask
  task automatic t_misc;
    for (int i = 0; i < 3; i++) begin
      host.put(ON, 1'b0, 1'b1, 1'b1, NW, BASE, '0);
      host.put(ON, 1'b1, 1'b1, 1'b1, NW, BASE, '0);
      host.put(ON ^ 3'(1 << i), 1'b1, 1'b0, 1'b1, NW, BASE, '0);
      chk({31'h0, dev_oe}, '0, "deselect");
    end
    host.put(ON, 1'b0, 1'b0, 1'b1, 6'h1F, BASE, 32'hDEADBEEF);
    host.put(ON, 1'b1, 1'b1, 1'b1, NW, BASE, '0);
    chk(dev_dq, pat(BASE), "both strobes");
    @(negedge clk);
    oe_n = 1'b1;
    host.put(ON, 1'b1, 1'b0, 1'b1, 6'h2A, BASE + 17'h1, 32'h11223344);
    host.put(ON, 1'b0, 1'b1, 1'b1, NW, BASE + 17'h1, '0);
    chk(dev_dq, {pat(BASE + 17'h1) & 32'hFF00FF00} | 32'h00220044,
        "byte lanes");
    @(negedge clk);
    oe_n = 1'b0;
    sleep = 1'b1;
    repeat (5) @(negedge clk);
    host.put(ON, 1'b1, 1'b0, 1'b1, 6'h1F, BASE + 17'h2, '0);
    chk({31'h0, dev_oe}, '0, "asleep");
    host.put(ON, 1'b1, 1'b1, 1'b1, NW, FAR, '0);
    @(negedge clk);
    sleep = 1'b0;
    repeat (5) @(negedge clk);
    host.put(ON, 1'b0, 1'b1, 1'b1, NW, BASE + 17'h2, '0);
    chk(dev_dq, pat(BASE + 17'h2), "sleep keeps data");
    $display("select, strobe, lane and sleep test done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_burst(1'b0, 2'h1);
    t_burst(1'b1, 2'h3);
    t_misc;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: run limit", $time);
    wrap_up;
  end
endmodule // sync_burst_sram_control_pins_test
